//--- verilog/mode_ctrl_pkg.sv
// constants, types and encodings for the operating-mode controller
// Overview of operation
// - interrupt output: held low or pulse
// - power-up: init reset, reset low, supply-loss flag
// - init reset to config; 256 ms timeout
// - init registers writable only in config
// - config re-entry only via secured procedure
// - config: buses, aux, I/O, mux off
// - watchdog fault or low supply enters reset
// - reset 1 ms; longer only for low supply
// - reset or wake leads to normal request
// - pass transistor on only in normal, flash
// - low power plain; others need secured procedure, except reset from flash, which takes the request alone
// - flash: 32 s watchdog, half-period interrupt in pulse mode
// - debug suppresses watchdog transitions, bus regulator on in config
// - debug left by pin drop or command
// - low power refused while wake flags set
// - supply-off mode kills mcu, bus, aux supplies
// - wake passes reset to normal request, recorded
// - command 0x5C10 wakes supply-on low power
// - over-current beyond selected time is wake
// - wake in supply-on mode pulses interrupt
// - supply-on timeout watchdog, refresh keeps mode
// - secured code fresh, altered echo, readable
// - refresh word 0x5A00 enters normal
package mode_ctrl_pkg;
    localparam int CLOCK_HZ = 125_000_000;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;
    localparam int RESET_US = 1000;
    localparam int CONFIG_TIMEOUT_MS = 256;
    localparam int NREQ_TIMEOUT_MS = 256;
    localparam int FLASH_PERIOD_S = 32;
    localparam int OVERCURRENT_MAX_MS = 32;
    localparam int RESET_TICKS = RESET_US / TICK_US;
    localparam int CONFIG_TICKS = CONFIG_TIMEOUT_MS * 1000 / TICK_US;
    localparam int NREQ_TICKS = NREQ_TIMEOUT_MS * 1000 / TICK_US;
    localparam int FLASH_TICKS = FLASH_PERIOD_S * 1_000_000 / TICK_US;
    localparam int OC_MAX_TICKS = OVERCURRENT_MAX_MS * 1000 / TICK_US;
    localparam logic [15:0] CMD_REFRESH = 16'h5A00;
    localparam logic [15:0] CMD_WAKE_NREQ = 16'h5C10;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [7:0] RANDOM_RESET = 8'h00;

    typedef enum logic [8:0] {
        ST_INIT_RESET = 9'h001,
        ST_CONFIG = 9'h002,
        ST_RESET = 9'h004,
        ST_NREQ = 9'h008,
        ST_NORMAL = 9'h010,
        ST_FLASH = 9'h020,
        ST_LP_ON = 9'h040,
        ST_LP_OFF = 9'h080,
        ST_LP_OFF_WAKE = 9'h100
    } mode_e;

    typedef enum logic [2:0] {
        REQ_RESET = 3'd1,
        REQ_CONFIG = 3'd2,
        REQ_FLASH = 3'd3,
        REQ_NONE = 3'd0
    } secure_req_e;

    typedef struct packed {
        logic bus_wake;
        logic timer_wake;
        logic io_wake;
        logic cyclic_wake;
    } wake_src_s;

    typedef struct packed {
        logic mcu_supply;
        logic bus_regulator;
        logic aux_regulator;
        logic bus_if;
        logic io_pins;
        logic analog_mux;
        logic pass_transistor;
    } power_gate_s;
endpackage : mode_ctrl_pkg

//--- verilog/mode_ctrl.sv
// operating-mode state machine with reset, interrupt and supply gating
`timescale 1ns/1ps
module mode_ctrl #(
    parameter int LONG_RESET_US = 4000,
    parameter int TICK_DIV = mode_ctrl_pkg::TICK_CYCLES,
    parameter int INT_PULSE_MAX = 255
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic cmd_is_init_reg,
    input wire logic cmd_write,
    input wire logic lp_off_req,
    input wire logic lp_on_req,
    input wire logic fail_safe_lp_off,
    input wire logic lp_refresh_cmd,
    input wire logic secure_request,
    input wire logic [2:0] secure_target,
    input wire logic secure_answer,
    input wire logic [7:0] secure_answer_code,
    input wire logic debug_exit_cmd,
    input wire logic wd_fault,
    input wire logic debug_select_pin,
    input wire logic supply_low,
    input wire logic overcurrent,
    input wire mode_ctrl_pkg::wake_src_s wake_in,
    input wire logic wake_flags_set,
    input wire logic int_event,
    input wire logic int_pulse_mode,
    input wire logic [7:0] int_pulse_len,
    input wire logic long_reset_sel,
    input wire logic [15:0] nreq_short_ticks,
    input wire logic nreq_short_sel,
    input wire logic [15:0] oc_sel_ticks,
    input wire logic lp_wd_enable,
    input wire logic [15:0] lp_wd_ticks,
    input wire logic flash_half_int_en,
    input wire logic supply_loss_clear,
    output logic reset_n_out,
    output logic reset_n_oe_n,
    output logic int_n,
    output mode_ctrl_pkg::mode_e mode_q,
    output mode_ctrl_pkg::power_gate_s gate_q,
    output logic init_write_ok_q,
    output logic debug_active_q,
    output logic supply_loss_q,
    output logic [7:0] random_code_q,
    output mode_ctrl_pkg::wake_src_s wake_record_q,
    output logic cmd_refused_q
);
    import mode_ctrl_pkg::*;

    // the time-base divider is only eight bits wide
    if (TICK_DIV < 1 || TICK_DIV > 256 || LONG_RESET_US < RESET_US || INT_PULSE_MAX < 1) begin : g_bad_params
        $error("mode_ctrl: unsupported parameter values");
    end

    // two-flop synchronisers for pin-level inputs
    logic dbg_s1_q, dbg_s2_q, sup_s1_q, sup_s2_q, oc_s1_q, oc_s2_q;
    wake_src_s wake_s1_q, wake_s2_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
            oc_s1_q <= 1'b0;
            oc_s2_q <= 1'b0;
            wake_s1_q <= '0;
            wake_s2_q <= '0;
        end else begin
            dbg_s1_q <= debug_select_pin;
            dbg_s2_q <= dbg_s1_q;
            sup_s1_q <= supply_low;
            sup_s2_q <= sup_s1_q;
            oc_s1_q <= overcurrent;
            oc_s2_q <= oc_s1_q;
            wake_s1_q <= wake_in;
            wake_s2_q <= wake_s1_q;
        end
    end

    // shared microsecond time base
    logic [7:0] div_q;
    logic tick;
    assign tick = (div_q == 8'(TICK_DIV - 1));
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    function automatic logic is_refresh(input logic v, input logic [15:0] w);
        return v && (w == CMD_REFRESH);
    endfunction : is_refresh

    mode_e mode_d;
    logic [25:0] tmr_q;
    logic entered;
    logic reset_long_q;
    logic secure_armed_q;
    secure_req_e secure_tgt_q;
    logic secure_ok;
    logic [15:0] oc_q;
    logic oc_wake, oc_short;
    logic refresh;
    logic any_wake;
    logic half_hit;

    assign refresh = is_refresh(cmd_valid, cmd_word);
    assign entered = (mode_d != mode_q);
    assign any_wake = |wake_s2_q;
    // altered echo is the bitwise complement of the issued code
    assign secure_ok = secure_answer && secure_armed_q && (secure_answer_code == ~random_code_q);
    assign oc_wake = oc_s2_q && (oc_q >= oc_sel_ticks) && (oc_sel_ticks <= 16'(OC_MAX_TICKS));
    assign oc_short = !oc_s2_q && (oc_q != 16'h0000) && (oc_q < oc_sel_ticks);
    assign half_hit = tick && (tmr_q == 26'(FLASH_TICKS / 2));

    // next-mode decision
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            ST_INIT_RESET: begin
                if (tick && tmr_q >= 26'(RESET_TICKS)) begin
                    mode_d = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (refresh) begin
                    mode_d = ST_NORMAL;
                end else if (!debug_active_q && tmr_q >= 26'(CONFIG_TICKS)) begin
                    mode_d = ST_INIT_RESET;
                end
            end
            ST_RESET: begin
                if (tmr_q >= (reset_long_q ? 26'(LONG_RESET_US) : 26'(RESET_TICKS))) begin
                    mode_d = ST_NREQ;
                end
            end
            ST_NREQ: begin
                if (wd_fault && !debug_active_q) begin
                    mode_d = ST_RESET;
                end else if (refresh) begin
                    mode_d = ST_NORMAL;
                end else if (sup_s2_q) begin
                    mode_d = ST_RESET;
                end else if (!debug_active_q && tmr_q >= (nreq_short_sel ? 26'(nreq_short_ticks) : 26'(NREQ_TICKS))) begin
                    mode_d = ST_RESET;
                end
            end
            ST_NORMAL: begin
                if (sup_s2_q || (wd_fault && !debug_active_q)) begin
                    mode_d = ST_RESET;
                end else if (secure_ok && secure_tgt_q == REQ_RESET) begin
                    mode_d = ST_RESET;
                end else if (secure_ok && secure_tgt_q == REQ_CONFIG) begin
                    mode_d = ST_CONFIG;
                end else if (secure_ok && secure_tgt_q == REQ_FLASH) begin
                    mode_d = ST_FLASH;
                end else if ((lp_off_req || fail_safe_lp_off) && !wake_flags_set) begin
                    mode_d = ST_LP_OFF;
                end else if (lp_on_req && !wake_flags_set) begin
                    mode_d = ST_LP_ON;
                end
            end
            ST_FLASH: begin
                if (sup_s2_q || secure_request && secure_target == 3'(REQ_RESET)) begin
                    mode_d = ST_RESET;
                end else if (!debug_active_q && (wd_fault || tmr_q >= 26'(FLASH_TICKS))) begin
                    mode_d = ST_RESET;
                end
            end
            ST_LP_ON: begin
                if (sup_s2_q) begin
                    mode_d = ST_RESET;
                end else if (any_wake || oc_wake || (cmd_valid && cmd_word == CMD_WAKE_NREQ)) begin
                    mode_d = ST_NREQ;
                end else if (lp_wd_enable && !debug_active_q && tmr_q >= 26'(lp_wd_ticks)) begin
                    mode_d = ST_RESET;
                end
            end
            ST_LP_OFF: begin
                if (any_wake) begin
                    mode_d = ST_LP_OFF_WAKE;
                end
            end
            ST_LP_OFF_WAKE: begin
                mode_d = ST_RESET;
            end
            default: begin
                mode_d = ST_INIT_RESET;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= ST_INIT_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // per-mode timeout counter, restarted on every mode entry
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tmr_q <= '0;
        end else if (entered || (mode_q == ST_LP_ON && (lp_refresh_cmd || oc_short))) begin
            tmr_q <= '0;
        end else if (mode_q == ST_FLASH && refresh) begin
            tmr_q <= '0;
        end else if (tick && tmr_q != '1) begin
            tmr_q <= tmr_q + 26'h0000001;
        end
    end

    // reset length chosen at the moment reset is entered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reset_long_q <= 1'b0;
        end else if (entered && mode_d == ST_RESET) begin
            reset_long_q <= sup_s2_q && long_reset_sel;
        end
    end

    // over-current duration in supply-on low power
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            oc_q <= '0;
        end else if (mode_q != ST_LP_ON || !oc_s2_q) begin
            oc_q <= '0;
        end else if (tick && oc_q != '1) begin
            oc_q <= oc_q + 16'h0001;
        end
    end

    // debug mode: caught once when init reset hands over to config
    // next value shared with the gating so the bus regulator never lags the flag
    logic debug_d;
    always_comb begin
        debug_d = debug_active_q;
        if (mode_q == ST_INIT_RESET && mode_d == ST_CONFIG) begin
            debug_d = dbg_s2_q;
        end else if (debug_exit_cmd || !dbg_s2_q) begin
            debug_d = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            debug_active_q <= 1'b0;
        end else begin
            debug_active_q <= debug_d;
        end
    end

    // free-running scrambler; the code is latched fresh on each request made in normal mode
    logic [15:0] lfsr_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lfsr_q <= LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            random_code_q <= RANDOM_RESET;
            secure_armed_q <= 1'b0;
            secure_tgt_q <= REQ_NONE;
        end else if (secure_request && mode_q == ST_NORMAL) begin
            random_code_q <= lfsr_q[7:0];
            secure_armed_q <= 1'b1;
            secure_tgt_q <= secure_req_e'(secure_target);
        end else if (secure_answer || entered) begin
            secure_armed_q <= 1'b0;
        end
    end

    // supply-loss flag: set wins over clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            supply_loss_q <= 1'b1;
        end else if (mode_q == ST_INIT_RESET) begin
            supply_loss_q <= 1'b1;
        end else if (supply_loss_clear) begin
            supply_loss_q <= 1'b0;
        end
    end

    // wake source record, sticky until the next low-power entry
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_record_q <= '0;
        end else if (entered && (mode_d == ST_LP_ON || mode_d == ST_LP_OFF)) begin
            wake_record_q <= '0;
        end else if (mode_q == ST_LP_ON || mode_q == ST_LP_OFF) begin
            wake_record_q <= wake_record_q | wake_s2_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            init_write_ok_q <= 1'b0;
            cmd_refused_q <= 1'b0;
        end else begin
            init_write_ok_q <= (mode_d == ST_CONFIG);
            cmd_refused_q <= (cmd_valid && cmd_write && cmd_is_init_reg && mode_q != ST_CONFIG)
                || ((lp_on_req || lp_off_req) && wake_flags_set);
        end
    end

    // supply and function gating by mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gate_q <= '0;
        end else begin
            gate_q.mcu_supply <= (mode_d != ST_LP_OFF);
            gate_q.bus_regulator <= (mode_d == ST_CONFIG) ? debug_d
                : !(mode_d inside {ST_LP_ON, ST_LP_OFF, ST_INIT_RESET});
            gate_q.aux_regulator <= !(mode_d inside {ST_CONFIG, ST_LP_ON, ST_LP_OFF, ST_INIT_RESET});
            gate_q.bus_if <= !(mode_d inside {ST_CONFIG, ST_LP_ON, ST_LP_OFF, ST_INIT_RESET});
            gate_q.io_pins <= !(mode_d inside {ST_CONFIG, ST_INIT_RESET});
            gate_q.analog_mux <= !(mode_d inside {ST_CONFIG, ST_LP_ON, ST_LP_OFF, ST_INIT_RESET});
            gate_q.pass_transistor <= (mode_d == ST_NORMAL || mode_d == ST_FLASH);
        end
    end

    // open-drain reset: oe low means driving low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reset_n_out <= 1'b0;
            reset_n_oe_n <= 1'b0;
        end else begin
            reset_n_out <= 1'b0;
            reset_n_oe_n <= !(mode_d inside {ST_INIT_RESET, ST_RESET});
        end
    end

    // interrupt: level or timed pulse; wake in supply-on mode forces a pulse
    logic [7:0] pulse_q;
    logic int_trig;
    assign int_trig = int_event || (mode_q == ST_FLASH && flash_half_int_en && half_hit)
        || (mode_q == ST_LP_ON && mode_d == ST_NREQ);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulse_q <= '0;
            int_n <= 1'b1;
        end else if (int_trig && (int_pulse_mode || mode_q == ST_LP_ON)) begin
            pulse_q <= (int_pulse_len == 8'h00) ? 8'h01 : int_pulse_len;
            int_n <= 1'b0;
        end else if (pulse_q != 8'h00) begin
            pulse_q <= tick ? pulse_q - 8'h01 : pulse_q;
            int_n <= (pulse_q == 8'h01 && tick);
        end else begin
            int_n <= !(int_event && !int_pulse_mode);
        end
    end
endmodule : mode_ctrl

//--- tb/mode_ctrl_props.sv
// port-level checks on the mode controller
`timescale 1ns/1ps
module mode_ctrl_props
    import mode_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic cmd_is_init_reg,
    input wire logic cmd_write,
    input wire logic lp_off_req,
    input wire logic lp_on_req,
    input wire logic wd_fault,
    input wire logic wake_flags_set,
    input wire logic secure_answer,
    input wire logic reset_n_out,
    input wire logic reset_n_oe_n,
    input wire mode_ctrl_pkg::mode_e mode_q,
    input wire mode_ctrl_pkg::power_gate_s gate_q,
    input wire logic debug_active_q,
    input wire logic cmd_refused_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire wr = cmd_valid && cmd_write;
    property p_refresh_normal;
        wr && cmd_word == CMD_REFRESH && mode_q inside {ST_CONFIG, ST_NREQ} |=>
            mode_q == ST_NORMAL && gate_q.pass_transistor;
    endproperty
    a_refresh_normal: assert property (p_refresh_normal) else $error("refresh did not reach normal");
    property p_pass_gate;
        gate_q.pass_transistor |-> mode_q inside {ST_NORMAL, ST_FLASH};
    endproperty
    a_pass_gate: assert property (p_pass_gate) else $error("pass transistor on in wrong mode");
    property p_reset_drive;
        mode_q inside {ST_INIT_RESET, ST_RESET} |-> !reset_n_oe_n && !reset_n_out;
    endproperty
    a_reset_drive: assert property (p_reset_drive) else $error("reset line not driven");
    property p_reset_hold;
        $rose(mode_q == ST_RESET) |-> (mode_q == ST_RESET && !reset_n_oe_n) [*8];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset pulse too short");
    property p_wd_reset;
        wd_fault && !debug_active_q && mode_q inside {ST_NORMAL, ST_NREQ, ST_FLASH} |=> mode_q == ST_RESET;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("watchdog fault ignored");
    property p_lp_refuse;
        (lp_on_req || lp_off_req) && wake_flags_set && mode_q == ST_NORMAL |=> cmd_refused_q && mode_q == ST_NORMAL;
    endproperty
    a_lp_refuse: assert property (p_lp_refuse) else $error("low power entered with wake flags");
    property p_init_refuse;
        wr && cmd_is_init_reg && mode_q != ST_CONFIG |=> cmd_refused_q;
    endproperty
    a_init_refuse: assert property (p_init_refuse) else $error("init write outside config accepted");
    property p_config_gates;
        mode_q == ST_CONFIG |-> !(gate_q.bus_if || gate_q.aux_regulator || gate_q.io_pins || gate_q.analog_mux)
            && (!gate_q.bus_regulator || debug_active_q);
    endproperty
    a_config_gates: assert property (p_config_gates) else $error("block active in config");
    property p_lp_off_gates;
        mode_q == ST_LP_OFF |-> !(gate_q.mcu_supply || gate_q.bus_regulator || gate_q.aux_regulator);
    endproperty
    a_lp_off_gates: assert property (p_lp_off_gates) else $error("supply on in supply-off mode");
    property p_flash_secured;
        mode_q == ST_NORMAL && !secure_answer |=> mode_q != ST_FLASH;
    endproperty
    a_flash_secured: assert property (p_flash_secured) else $error("flash without secured answer");
    property p_wake_cmd;
        wr && cmd_word == CMD_WAKE_NREQ && mode_q == ST_LP_ON |=> mode_q == ST_NREQ;
    endproperty
    a_wake_cmd: assert property (p_wake_cmd) else $error("wake command ignored");
    c_flash: cover property (mode_q == ST_FLASH);
    c_lp_on: cover property (mode_q == ST_LP_ON);
    c_lp_off: cover property (mode_q == ST_LP_OFF);
    c_refused: cover property (cmd_refused_q);
endmodule : mode_ctrl_props

bind mode_ctrl mode_ctrl_props i_mode_ctrl_props (.clock, .rst, .cmd_valid, .cmd_word, .cmd_is_init_reg,
    .cmd_write, .lp_off_req, .lp_on_req, .wd_fault, .wake_flags_set, .secure_answer, .reset_n_out,
    .reset_n_oe_n, .mode_q, .gate_q, .debug_active_q, .cmd_refused_q);

//--- tb/host_model.sv
// host stand-in: secured answers and the reset line it sees
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    input wire logic go,
    input wire logic bad,
    input wire logic [7:0] random_code_q,
    input wire logic reset_n_out,
    input wire logic reset_n_oe_n,
    output logic secure_answer,
    output logic [7:0] secure_answer_code,
    output logic mcu_reset_n
);
    logic req = 1'h0;
    logic [7:0] code = 8'h00;
    initial secure_answer = 1'h0;
    initial secure_answer_code = 8'h00;
    // open drain with pull-up
    assign mcu_reset_n = reset_n_oe_n ? 1'h1 : reset_n_out;
    always @(posedge clock) begin
        req = go;
        code = bad ? random_code_q : ~random_code_q;
        #1;
        secure_answer = req;
        // idle code toggles so a stale value never looks like an answer
        secure_answer_code = req ? code : ~secure_answer_code;
    end
endmodule : host_model

//--- tb/mode_ctrl_tb.sv
// self-checking bench for the mode controller
`timescale 1ns/1ps
module mode_ctrl_tb;
    import mode_ctrl_pkg::*;
    logic clock = 1'h0, rst = 1'h1, cmd_valid = 1'h0, cmd_is_init_reg = 1'h0, cmd_write = 1'h1;
    logic fail_safe_lp_off = 1'h0, lp_refresh_cmd = 1'h0, debug_exit_cmd = 1'h0, debug_select_pin = 1'h0;
    logic overcurrent = 1'h0, wake_flags_set = 1'h0, int_event = 1'h0, int_pulse_mode = 1'h0;
    logic long_reset_sel = 1'h1, nreq_short_sel = 1'h0, lp_wd_enable = 1'h0, flash_half_int_en = 1'h0;
    logic go = 1'h0, bad = 1'h0, secure_answer, mcu_reset_n;
    logic [15:0] cmd_word = 16'h0000, nreq_short_ticks = 16'h0100, oc_sel_ticks = 16'h0100, lp_wd_ticks = 16'h0100;
    logic [7:0] secure_answer_code, c, int_pulse_len = 8'h04;
    logic [2:0] secure_target = 3'h0;
    logic [6:0] pls = 7'h00;
    wire lp_on_req = pls[0];
    wire lp_off_req = pls[1];
    wire wd_fault = pls[2];
    wire secure_request = pls[3];
    wire supply_low = pls[4];
    wire supply_loss_clear = pls[6];
    wire [3:0] wake_in = {pls[5], 3'h0};
    logic reset_n_out, reset_n_oe_n, int_n, init_write_ok_q, debug_active_q, supply_loss_q, cmd_refused_q;
    mode_e mode_q;
    power_gate_s gate_q;
    logic [7:0] random_code_q;
    wake_src_s wake_record_q;
    int failures = 0, n_tests = 0, cycles = 0, n;
    typedef struct packed {
        logic [3:0] op;
        mode_e m;
        logic pass;
        logic [15:0] len;
    } row_s;
    // op 0 refresh, 1..7 pulse bit op-1, 8 wake word, 9 secured flash, A reset request with no answer
    localparam row_s ROWS [14] = '{
        '{4'h0, ST_NORMAL, 1'h1, 16'h0000}, '{4'h1, ST_LP_ON, 1'h0, 16'h0000},
        '{4'h8, ST_NREQ, 1'h0, 16'h0000}, '{4'h0, ST_NORMAL, 1'h1, 16'h0000},
        '{4'h9, ST_FLASH, 1'h1, 16'h0000}, '{4'hA, ST_NREQ, 1'h0, 16'h03E8},
        '{4'h0, ST_NORMAL, 1'h1, 16'h0000}, '{4'h3, ST_NREQ, 1'h0, 16'h03E8},
        '{4'h0, ST_NORMAL, 1'h1, 16'h0000}, '{4'h5, ST_NREQ, 1'h0, 16'h0FA0},
        '{4'h0, ST_NORMAL, 1'h1, 16'h0000}, '{4'h2, ST_LP_OFF, 1'h0, 16'h0000},
        '{4'h6, ST_NREQ, 1'h0, 16'h03E8}, '{4'h0, ST_NORMAL, 1'h1, 16'h0000}};

    mode_ctrl #(.TICK_DIV(1)) i_mode_ctrl (.clock, .rst, .cmd_valid, .cmd_word, .cmd_is_init_reg, .cmd_write,
        .lp_off_req, .lp_on_req, .fail_safe_lp_off, .lp_refresh_cmd, .secure_request, .secure_target,
        .secure_answer, .secure_answer_code, .debug_exit_cmd, .wd_fault, .debug_select_pin, .supply_low,
        .overcurrent, .wake_in, .wake_flags_set, .int_event, .int_pulse_mode, .int_pulse_len, .long_reset_sel,
        .nreq_short_ticks, .nreq_short_sel, .oc_sel_ticks, .lp_wd_enable, .lp_wd_ticks, .flash_half_int_en,
        .supply_loss_clear, .reset_n_out, .reset_n_oe_n, .int_n, .mode_q, .gate_q, .init_write_ok_q,
        .debug_active_q, .supply_loss_q, .random_code_q, .wake_record_q, .cmd_refused_q);
    host_model i_host_model (.clock, .go, .bad, .random_code_q, .reset_n_out, .reset_n_oe_n, .secure_answer,
        .secure_answer_code, .mcu_reset_n);

    initial forever #4 clock = ~clock;

    task automatic print_verdict;
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick

    task automatic pulse(input logic [3:0] b, input int k);
        pls[b] = 1'h1;
        repeat (k) tick();
        pls[b] = 1'h0;
    endtask : pulse

    task automatic send(input logic [15:0] w, input logic init);
        cmd_valid = 1'h1;
        cmd_word = w;
        cmd_is_init_reg = init;
        tick();
        cmd_valid = 1'h0;
        cmd_word = ~w;
    endtask : send

    task automatic wait_mode(input mode_e m, output int k);
        k = 0;
        while (mode_q !== m && k < 5000) begin
            tick();
            k++;
        end
        check(16'(mode_q), 16'(m));
    endtask : wait_mode

    task automatic do_op(input logic [3:0] op);
        // idle cycle keeps back-to-back commands apart
        tick();
        if (op == 4'h0) send(CMD_REFRESH, 1'h0);
        else if (op == 4'h8) send(CMD_WAKE_NREQ, 1'h0);
        else if (op >= 4'h9) begin
            secure_target = (op == 4'h9) ? REQ_FLASH : REQ_RESET;
            pulse(4'h3, 1);
            go = (op == 4'h9);
            tick();
            go = 1'h0;
        end else pulse(op - 4'h1, (op >= 4'h5) ? 4 : 1);
    endtask : do_op

    // a hang ends the run instead of stalling it
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        #1;
        check(16'(mode_q), 16'(ST_INIT_RESET));
        check(16'({reset_n_oe_n, mcu_reset_n, int_n, supply_loss_q}), 16'h3);
        rst = 1'h0;
        wait_mode(ST_CONFIG, n);
        check(16'(n >= 990 && n <= 1010), 16'h1);
        check(16'(init_write_ok_q), 16'h1);
        send(16'h1100, 1'h1);
        check(16'(cmd_refused_q), 16'h0);
        foreach (ROWS[i]) begin
            do_op(ROWS[i].op);
            wait_mode(ROWS[i].m, n);
            check(16'(gate_q.pass_transistor), 16'(ROWS[i].pass));
            if (ROWS[i].op == 4'h8) check(16'(int_n), 16'h0);
            if (ROWS[i].len != 16'h0) check(16'(n + 8 >= ROWS[i].len && n <= ROWS[i].len + 16), 16'h1);
        end
        check(16'(wake_record_q), 16'h0008);
        check(16'(supply_loss_q), 16'h1);
        pulse(4'h6, 1);
        check(16'(supply_loss_q), 16'h0);
        wake_flags_set = 1'h1;
        pulse(4'h0, 1);
        check(16'({cmd_refused_q, mode_q}), 16'({1'h1, ST_NORMAL}));
        wake_flags_set = 1'h0;
        send(16'h1100, 1'h1);
        check(16'(cmd_refused_q), 16'h1);
        c = random_code_q;
        bad = 1'h1;
        do_op(4'h9);
        bad = 1'h0;
        tick();
        tick();
        check(16'(mode_q), 16'(ST_NORMAL));
        check(16'(c !== random_code_q), 16'h1);
        int_event = 1'h1;
        tick();
        tick();
        check(16'(int_n), 16'h0);
        int_pulse_mode = 1'h1;
        tick();
        int_event = 1'h0;
        repeat (3) tick();
        check(16'(int_n), 16'h0);
        tick();
        check(16'(int_n), 16'h1);
        rst = 1'h1;
        debug_select_pin = 1'h1;
        tick();
        rst = 1'h0;
        wait_mode(ST_CONFIG, n);
        check(16'({debug_active_q, gate_q.bus_regulator, supply_loss_q}), 16'h7);
        debug_exit_cmd = 1'h1;
        tick();
        debug_exit_cmd = 1'h0;
        check(16'(debug_active_q), 16'h0);
        print_verdict();
    end
endmodule : mode_ctrl_tb
